// file: logic/wdtc_top.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps

// How it works
// - unlock bit self-clears four clocks after set
// - enable on one; disable only while unlocked
// - zero to enable while locked is ignored
// - timeout select changes only while unlocked
// - timeout is 16K oscillator ticks doubled per code
// - lower level starts disabled, enable freely
// - higher level always enabled, reads one
// - higher level refuses every disable attempt
// - higher level completing write takes select only
// - expiry gives one-clock internal reset pulse
// - counter clears on restart, disable, reset
// - fuse picks safety level and start state
// - counter runs from separate oscillator ticks
module wdtc_top #(
   parameter int CNT_W      = wdtc_pkg::CNT_W,
   parameter int BASE_TICKS = wdtc_pkg::BASE_TICKS
) (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       restart_i,
   input  wire logic       safety_level_fuse_i,
   input  wire logic       wdog_osc_i,
   output logic            dog_reset_o,
   output logic            irq_o
);

   // oscillator tick and fuse level, both brought into clk_i
   logic                   osc_tick;
   logic                   fuse_lvl2;

   // configuration state
   logic [2:0]             win_cnt_r;
   logic [2:0]             win_cnt_nxt;
   logic                   en_r;
   logic                   en_nxt;
   logic [2:0]             timeout_select_r;
   logic [2:0]             timeout_select_nxt;

   // counter state
   logic [CNT_W-1:0]       cnt_r;
   logic [CNT_W-1:0]       cnt_nxt;
   logic                   dog_reset_r;
   logic                   fire;

   // interrupt and read state
   logic [1:0]             stat_r;
   logic [1:0]             stat_nxt;
   logic [1:0]             mask_r;
   logic [1:0]             mask_nxt;
   logic [7:0]             rdata_r;
   logic [7:0]             rdata_nxt;

   // decoded access and derived values
   logic                   wr_ctrl;
   logic                   unlock_wr;
   logic                   finish_wr;
   logic                   unlock_open;
   logic                   en_eff;
   logic                   refused;
   logic [CNT_W-1:0]       limit_w;
   logic [CNT_W-1:0]       limit_m1_w;
   logic [7:0]             ctrl_view;

   // oscillator ticks and the fuse level arrive from outside clk_i
   wdtc_osc_sync u_osc_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (wdog_osc_i),
      .level_o   (),
      .rise_o    (osc_tick)
   );

   wdtc_osc_sync u_fuse_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (safety_level_fuse_i),
      .level_o   (fuse_lvl2),
      .rise_o    ()
   );

   // access decode for dog_control_reg
   assign wr_ctrl     = wr_i && (addr_i == wdtc_pkg::CTRL_ADDR);
   assign unlock_open = (win_cnt_r != 3'h0);
   assign unlock_wr   = wr_ctrl && wdata_i[wdtc_pkg::UNLOCK_BIT]
                        && wdata_i[wdtc_pkg::ENABLE_BIT];
   assign finish_wr   = wr_ctrl && unlock_open
                        && !wdata_i[wdtc_pkg::UNLOCK_BIT];

   // higher level forces the timer on whatever en_r holds
   assign en_eff      = en_r || fuse_lvl2;

   // enable, select and unlock window
   always_comb begin
      win_cnt_nxt        = win_cnt_r;
      en_nxt             = en_r;
      timeout_select_nxt = timeout_select_r;
      if (unlock_open) begin
         win_cnt_nxt = win_cnt_r - 3'h1;
      end
      if (unlock_wr) begin
         win_cnt_nxt = wdtc_pkg::WINDOW_LOAD;
         en_nxt      = 1'b1;
      end else if (finish_wr) begin
         win_cnt_nxt        = 3'h0;
         timeout_select_nxt = wdata_i[wdtc_pkg::SEL_MSB -: wdtc_pkg::SEL_W];
         if (!fuse_lvl2) begin
            en_nxt = wdata_i[wdtc_pkg::ENABLE_BIT];
         end
      end else if (wr_ctrl && wdata_i[wdtc_pkg::ENABLE_BIT]) begin
         en_nxt = 1'b1;
      end
   end

   // a zero to the enable bit that does not take effect
   assign refused = wr_ctrl && en_eff && !wdata_i[wdtc_pkg::ENABLE_BIT]
                    && !(finish_wr && !fuse_lvl2);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         win_cnt_r        <= 3'h0;
         en_r             <= 1'b0;
         timeout_select_r <= wdtc_pkg::SEL_RESET;
      end else begin
         win_cnt_r        <= win_cnt_nxt;
         en_r             <= en_nxt;
         timeout_select_r <= timeout_select_nxt;
      end
   end

   // time-out length in oscillator ticks
   assign limit_w    = CNT_W'(BASE_TICKS) << timeout_select_r;
   assign limit_m1_w = limit_w - CNT_W'(1);

   // watchdog counter and expiry
   always_comb begin
      cnt_nxt = cnt_r;
      fire    = 1'b0;
      if (!en_eff || restart_i) begin
         cnt_nxt = '0;
      end else if (osc_tick) begin
         if (cnt_r == limit_m1_w) begin
            cnt_nxt = '0;
            fire    = 1'b1;
         end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r       <= '0;
         dog_reset_r <= 1'b0;
      end else begin
         cnt_r       <= cnt_nxt;
         dog_reset_r <= fire;
      end
   end

   assign dog_reset_o = dog_reset_r;

   // sticky events, cleared by writing one, set wins over clear
   always_comb begin
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      if (wr_i && (addr_i == wdtc_pkg::STAT_ADDR)) begin
         stat_nxt = stat_r & ~wdata_i[1:0];
      end
      if (wr_i && (addr_i == wdtc_pkg::MASK_ADDR)) begin
         mask_nxt = wdata_i[1:0];
      end
      if (fire) begin
         stat_nxt[wdtc_pkg::EV_TIMEOUT] = 1'b1;
      end
      if (refused) begin
         stat_nxt[wdtc_pkg::EV_REFUSED] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stat_r <= wdtc_pkg::STAT_RESET;
         mask_r <= wdtc_pkg::MASK_RESET;
      end else begin
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
      end
   end

   assign irq_o = |(stat_r & mask_r);

   // read data one cycle after the strobe, zero otherwise
   assign ctrl_view = {3'h0, unlock_open, en_eff, timeout_select_r};

   always_comb begin
      rdata_nxt = wdtc_pkg::RDATA_RESET;
      if (rd_i) begin
         case (addr_i)
            wdtc_pkg::CTRL_ADDR: rdata_nxt = ctrl_view;
            wdtc_pkg::STAT_ADDR: rdata_nxt = {6'h00, stat_r};
            wdtc_pkg::MASK_ADDR: rdata_nxt = {6'h00, mask_r};
            default:             rdata_nxt = wdtc_pkg::RDATA_RESET;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_r <= wdtc_pkg::RDATA_RESET;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata_o = rdata_r;

   // checks on the configuration and counter behaviour
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_unlock_closes: assert property (
      unlock_wr ##1 (!unlock_wr)[*4] |=> !unlock_open)
      else $error("unlock window stayed open past four clocks");

   a_enable_on_one: assert property (
      wr_ctrl && wdata_i[wdtc_pkg::ENABLE_BIT] |=> en_eff)
      else $error("write of one did not enable the timer");

   a_locked_zero_ignored: assert property (
      wr_ctrl && !unlock_open && !wdata_i[wdtc_pkg::ENABLE_BIT] && en_eff
      |=> en_eff)
      else $error("locked disable write took effect");

   a_select_locked: assert property (
      !finish_wr |=> timeout_select_r == $past(timeout_select_r))
      else $error("timeout select changed outside a completing write");

   a_expiry_count: assert property (
      dog_reset_o |-> $past(cnt_r) == $past(limit_m1_w) && $past(osc_tick))
      else $error("reset pulse not at the selected count");

   a_lvl1_disable: assert property (
      finish_wr && !fuse_lvl2 && !wdata_i[wdtc_pkg::ENABLE_BIT]
      |=> !en_eff ##1 cnt_r == '0)
      else $error("timed disable failed or counter not cleared");

   a_lvl2_enabled: assert property (
      fuse_lvl2 && rd_i && (addr_i == wdtc_pkg::CTRL_ADDR)
      |=> rdata_o[wdtc_pkg::ENABLE_BIT])
      else $error("higher level shows timer disabled");

   a_lvl2_no_disable: assert property (
      fuse_lvl2 && wr_ctrl && !wdata_i[wdtc_pkg::ENABLE_BIT]
      |=> en_eff && stat_r[wdtc_pkg::EV_REFUSED])
      else $error("higher level disable not refused");

   a_lvl2_takes_sel: assert property (
      fuse_lvl2 && finish_wr
      |=> timeout_select_r == $past(wdata_i[2:0]) && en_eff)
      else $error("completing write at higher level mishandled");

   a_pulse_one_clk: assert property (
      dog_reset_o |=> !dog_reset_o)
      else $error("reset pulse longer than one clock");

   a_restart_clears: assert property (
      restart_i || !en_eff |=> cnt_r == '0)
      else $error("counter not cleared by restart or disable");

   a_tick_only: assert property (
      cnt_r != $past(cnt_r) && cnt_r != '0 |-> $past(osc_tick))
      else $error("counter advanced without an oscillator tick");

   a_late_write: assert property (
      wr_ctrl && !unlock_open && !wdata_i[wdtc_pkg::UNLOCK_BIT]
      |=> en_eff == ($past(en_eff) || $past(wdata_i[3]))
          && timeout_select_r == $past(timeout_select_r))
      else $error("late completing write changed the configuration");

   a_window_load: assert property (
      unlock_wr |=> win_cnt_r == wdtc_pkg::WINDOW_LOAD)
      else $error("unlock write did not load the window");

   a_timeout_flag: assert property (
      fire |=> stat_r[wdtc_pkg::EV_TIMEOUT] && dog_reset_o)
      else $error("expiry did not raise its pulse and flag");

   a_refused_flag: assert property (
      refused |=> stat_r[wdtc_pkg::EV_REFUSED])
      else $error("refused disable did not raise its flag");

endmodule

// file: logic/wdtc_pkg.sv
package wdtc_pkg;

   // register addresses on the plain register port
   localparam logic [7:0] CTRL_ADDR       = 8'h60;
   localparam logic [7:0] STAT_ADDR       = 8'h61;
   localparam logic [7:0] MASK_ADDR       = 8'h62;

   // field positions inside dog_control_reg
   localparam int         UNLOCK_BIT      = 4;
   localparam int         ENABLE_BIT      = 3;
   localparam int         SEL_MSB         = 2;
   localparam int         SEL_W           = 3;

   // field positions inside the event status and mask registers
   localparam int         EV_TIMEOUT      = 0;
   localparam int         EV_REFUSED      = 1;
   localparam int         EV_W            = 2;

   // reset values
   localparam logic [2:0] SEL_RESET       = 3'h0;
   localparam logic [1:0] STAT_RESET      = 2'h0;
   localparam logic [1:0] MASK_RESET      = 2'h0;
   localparam logic [7:0] RDATA_RESET     = 8'h00;

   // timing: system clock and watchdog oscillator
   localparam int         CLK_PERIOD_NS   = 5;
   localparam int         OSC_FREQ_KHZ    = 1000;
   localparam int         WINDOW_CYCLES   = 4;
   localparam logic [2:0] WINDOW_LOAD     = 3'(WINDOW_CYCLES);
   localparam int         BASE_TICKS      = 16384;
   localparam int         CNT_W           = 22;

endpackage

// file: logic/wdtc_osc_sync.sv
`timescale 1ns/100ps

// three-stage synchroniser with agreement filter and rising-edge pulse
module wdtc_osc_sync (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o
);

   logic stage1_r;
   logic stage2_r;
   logic stage3_r;
   logic level_r;
   logic level_nxt;
   logic rise_r;
   logic rise_nxt;

   // a change counts once stages two and three agree
   always_comb begin
      level_nxt = level_r;
      if (stage2_r == stage3_r) begin
         level_nxt = stage3_r;
      end
      rise_nxt = level_nxt && !level_r;
   end

   // the first stage feeds only the second
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stage1_r <= 1'b0;
         stage2_r <= 1'b0;
         stage3_r <= 1'b0;
         level_r  <= 1'b0;
         rise_r   <= 1'b0;
      end else begin
         stage1_r <= async_i;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
         level_r  <= level_nxt;
         rise_r   <= rise_nxt;
      end
   end

   assign level_o = level_r;
   assign rise_o  = rise_r;

endmodule

// file: tb/wdtc_top_tb.sv
`timescale 1ns/100ps

module wdtc_top_tb;
   localparam int BASE = 4;
   localparam int OSCC = 10;
   localparam logic [7:0] CA = wdtc_pkg::CTRL_ADDR;
   localparam logic [7:0] SA = wdtc_pkg::STAT_ADDR;
   localparam logic [7:0] MA = wdtc_pkg::MASK_ADDR;
   logic       clk_i;
   logic       reset_n_i;
   logic [7:0] addr_i;
   logic [7:0] wdata_i;
   logic       wr_i;
   logic       rd_i;
   logic [7:0] rdata_o;
   logic       restart_i;
   logic       safety_level_fuse_i;
   logic       wdog_osc_i;
   logic       dog_reset_o;
   logic       irq_o;
   logic [7:0] d;
   int         n;
   int         failures;
   int         compares;

   wdtc_top #(.BASE_TICKS(BASE)) wdtc_top_inst (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .restart_i(restart_i), .safety_level_fuse_i(safety_level_fuse_i),
      .wdog_osc_i(wdog_osc_i), .dog_reset_o(dog_reset_o), .irq_o(irq_o)
   );

   // system clock and free running watchdog oscillator, ten clocks a tick
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      wdog_osc_i = 1'b0;
      #1.3;
      forever #25 wdog_osc_i = ~wdog_osc_i;
   end

   // comparison and reporting
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // register port cycles
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask
   task crd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      check(v, e);
   endtask
   // unlock write, then k idle cycles: next strobe lands k+2 cycles later
   task open_win(input int k);
      wr(CA, 8'h18);
      repeat (k) @(posedge clk_i);
   endtask
   // cycles until the next reset pulse, then a check that it lasts one clock
   task wait_pulse(input int lim, output int c);
      c = 1;
      do begin
         @(posedge clk_i);
         #1;
         c++;
      end while (dog_reset_o !== 1'b1 && c < lim);
      @(posedge clk_i);
      #1;
      check(dog_reset_o, 1'b0);
   endtask

   task t_reset();
      crd(CA, 8'h00);
      crd(SA, 8'h00);
      crd(MA, 8'h00);
      wr(8'h7f, 8'hff);
      crd(8'h7f, 8'h00);
      $display("test reset done");
   endtask

   task t_enable();
      wr(CA, 8'h08);
      crd(CA, 8'h08);
      wr(CA, 8'h00);
      crd(CA, 8'h08);
      wr(CA, 8'h0d);
      crd(CA, 8'h08);
      crd(SA, 8'h02);
      wr(MA, 8'h02);
      #1 check(irq_o, 1'b1);
      wr(SA, 8'h02);
      #1 check(irq_o, 1'b0);
      $display("test enable done");
   endtask

   task t_window();
      open_win(2);
      crd(CA, 8'h18);
      open_win(3);
      crd(CA, 8'h08);
      open_win(3);
      wr(CA, 8'h02);
      crd(CA, 8'h08);
      open_win(2);
      wr(CA, 8'h05);
      crd(CA, 8'h05);
      wr(CA, 8'h08);
      crd(CA, 8'h0d);
      wr(SA, 8'h03);
      $display("test window done");
   endtask

   task t_timeout();
      for (int c = 0; c < 8; c++) begin
         open_win(0);
         wr(CA, 8'h08 | 8'(c));
         wait_pulse(12000, n);
         wait_pulse(12000, n);
         check(n, (BASE << c) * OSCC);
      end
      crd(SA, 8'h01);
      wr(MA, 8'h01);
      #1 check(irq_o, 1'b1);
      wr(SA, 8'h01);
      #1 check(irq_o, 1'b0);
      $display("test timeout done");
   endtask

   task t_restart();
      open_win(0);
      wr(CA, 8'h09);
      wait_pulse(2000, n);
      @(posedge clk_i);
      restart_i <= 1'b1;
      wait_pulse(300, n);
      check(n, 300);
      @(posedge clk_i);
      restart_i <= 1'b0;
      wait_pulse(2000, n);
      check(n >= 70 && n <= 90, 1'b1);
      $display("test restart done");
   endtask

   task t_level2();
      open_win(0);
      wr(CA, 8'h01);
      crd(CA, 8'h01);
      @(posedge clk_i);
      safety_level_fuse_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      crd(CA, 8'h09);
      open_win(2);
      wr(CA, 8'h02);
      crd(CA, 8'h0a);
      wr(CA, 8'h00);
      rd(SA, d);
      check(d & 8'h02, 8'h02);
      wait_pulse(2000, n);
      check(n < 2000, 1'b1);
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      safety_level_fuse_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      crd(CA, 8'h00);
      $display("test level2 done");
   endtask

   // main sequence
   initial begin
      failures = 0;
      compares = 0;
      reset_n_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      restart_i = 1'b0;
      safety_level_fuse_i = 1'b0;
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_enable();
      t_window();
      t_timeout();
      t_restart();
      t_level2();
      summarize();
   end

   // hang guard, well past the longest expected run
   initial begin
      #300us;
      failures++;
      summarize();
   end
endmodule
